// ### aoe_size_offset_enc.sv
// Operation
// - Length over 85 m or width over 90 m gives size category 15.
// - Pick smallest category whose length and width bounds both cover the aircraft.
// - Size category is four ME bits 21..24; zero means no data.
// - Each category below 15 means dimensions at or below its upper bounds.
// - Separate lateral and longitudinal antenna offset fields are produced.
// - Both offset magnitudes are quantised in 2 metre steps.
// - Lateral field is direction bit 33 (right=1) then magnitude bits 34..35.
// - Lateral magnitude codes 1, 2, 3 mean 2, 4, 6 metres to the nearest step.
// - Lateral offsets beyond 6 m saturate to the 6 m code.
// - Lateral 000 means no data, 100 means zero offset.
// - Offsets round to the nearest 2 m step, tolerance 1 m; a longitudinal offset under 1 m goes out as the 2 m code.
// - Longitudinal field is ME bits 36..40; 0 no data, 1 sensor-applied.
// - Longitudinal codes 2..31 are offset metres divided by two plus one.
// - Longitudinal offsets beyond 60 m saturate to code 31.
`default_nettype none

module aoe_size_offset_enc (
  input  wire logic                            clock_i,
  input  wire logic                            rst_n_i,
  input  wire logic                            dim_valid_i,
  input  wire logic [aoe_pkg::DIM_W-1:0]       length_hm_i,
  input  wire logic [aoe_pkg::DIM_W-1:0]       width_hm_i,
  input  wire logic                            lat_valid_i,
  input  wire logic                            lat_right_i,
  input  wire logic [aoe_pkg::LAT_DIST_W-1:0]  lat_dist_dm_i,
  input  wire logic                            lon_valid_i,
  input  wire logic                            lon_applied_i,
  input  wire logic [aoe_pkg::LON_DIST_W-1:0]  lon_dist_dm_i,
  output logic      [aoe_pkg::SIZE_W-1:0]      size_code_o,
  output logic      [aoe_pkg::LAT_W-1:0]       lat_code_o,
  output logic      [aoe_pkg::LON_W-1:0]       lon_code_o,
  output logic                                 size_over_o,
  output logic                                 lat_sat_o,
  output logic                                 lon_sat_o
);

  logic [aoe_pkg::NUM_SIZE_CODES:1] fits;
  logic [aoe_pkg::LAT_MAG_W-1:0]    lat_steps;
  logic                             lat_over;
  logic [aoe_pkg::LON_W-1:0]        lon_steps;
  logic                             lon_over;

  logic [aoe_pkg::SIZE_W-1:0] size_d, size_q;
  logic [aoe_pkg::LAT_W-1:0]  lat_d, lat_q;
  logic [aoe_pkg::LON_W-1:0]  lon_d, lon_q;
  logic                       size_over_d, size_over_q;
  logic                       lat_sat_d, lat_sat_q;
  logic                       lon_sat_d, lon_sat_q;

  // One fit test per category: both dimensions at or under its bounds
  for (genvar c = 1; c <= aoe_pkg::NUM_SIZE_CODES; c++) begin : g_fit
    assign fits[c] = (length_hm_i <= aoe_pkg::LEN_BOUND_HM[c]) &&
                     (width_hm_i  <= aoe_pkg::WID_BOUND_HM[c]);
  end

  // Lateral magnitude: nearest 2 m step, capped at 6 m
  aoe_offset_quant #(
    .DIST_W    (aoe_pkg::LAT_DIST_W),
    .OUT_W     (aoe_pkg::LAT_MAG_W),
    .STEP      (aoe_pkg::OFFSET_STEP_DM),
    .HALF      (aoe_pkg::OFFSET_HALF_DM),
    .MAX_STEPS (aoe_pkg::LAT_MAX_STEPS)
  ) u_lat_quant (
    .dist_i  (lat_dist_dm_i),
    .steps_o (lat_steps),
    .sat_o   (lat_over)
  );

  // Longitudinal magnitude: nearest 2 m step, capped at 60 m
  aoe_offset_quant #(
    .DIST_W    (aoe_pkg::LON_DIST_W),
    .OUT_W     (aoe_pkg::LON_W),
    .STEP      (aoe_pkg::OFFSET_STEP_DM),
    .HALF      (aoe_pkg::OFFSET_HALF_DM),
    .MAX_STEPS (aoe_pkg::LON_MAX_STEPS)
  ) u_lon_quant (
    .dist_i  (lon_dist_dm_i),
    .steps_o (lon_steps),
    .sat_o   (lon_over)
  );

  // Size category: lowest fitting code wins, so the larger bound decides
  always_comb begin
    size_d      = aoe_pkg::SIZE_OVERSIZE;
    size_over_d = 1'b0;
    if (!dim_valid_i) begin
      size_d = aoe_pkg::SIZE_NO_DATA;
    end else begin
      // Scan from the top so the last hit is the smallest code
      for (int c = aoe_pkg::NUM_SIZE_CODES; c >= 1; c--) begin
        if (fits[c]) begin
          size_d = aoe_pkg::SIZE_W'(c);
        end
      end
      size_over_d = !fits[aoe_pkg::NUM_SIZE_CODES];
    end
  end

  // Lateral field: direction bit above a two-bit magnitude
  always_comb begin
    lat_d     = aoe_pkg::LAT_NO_DATA;
    lat_sat_d = 1'b0;
    if (lat_valid_i) begin
      if (lat_steps == '0) begin
        // A zero offset has no side; it always goes out as right-zero
        lat_d = aoe_pkg::LAT_ZERO;
      end else begin
        lat_d = {lat_right_i, lat_steps};
      end
      lat_sat_d = lat_over;
    end
  end

  // Longitudinal field: sensor-applied flag overrides the distance
  always_comb begin
    lon_d     = aoe_pkg::LON_NO_DATA;
    lon_sat_d = 1'b0;
    if (lon_valid_i) begin
      if (lon_applied_i) begin
        lon_d = aoe_pkg::LON_APPLIED;
      end else if (lon_steps == '0) begin
        // Code 1 is taken, so an offset under 1 m goes out as the 2 m code
        lon_d = aoe_pkg::LON_MIN_CODE;
      end else begin
        lon_d     = lon_steps + aoe_pkg::LON_CODE_BIAS;
        lon_sat_d = lon_over;
      end
    end
  end

  // Output registers: every field holds its no-data code out of reset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      size_q      <= aoe_pkg::SIZE_NO_DATA;
      lat_q       <= aoe_pkg::LAT_NO_DATA;
      lon_q       <= aoe_pkg::LON_NO_DATA;
      size_over_q <= 1'b0;
      lat_sat_q   <= 1'b0;
      lon_sat_q   <= 1'b0;
    end else begin
      size_q      <= size_d;
      lat_q       <= lat_d;
      lon_q       <= lon_d;
      size_over_q <= size_over_d;
      lat_sat_q   <= lat_sat_d;
      lon_sat_q   <= lon_sat_d;
    end
  end

  // Field MSB is the first ME bit of each field (21, 33, 36)
  assign size_code_o = size_q;
  assign lat_code_o  = lat_q;
  assign lon_code_o  = lon_q;
  assign size_over_o = size_over_q;
  assign lat_sat_o   = lat_sat_q;
  assign lon_sat_o   = lon_sat_q;

endmodule // aoe_size_offset_enc

`default_nettype wire

// ### aoe_pkg.sv
`default_nettype none

package aoe_pkg;

  // Input units: half metres for dimensions, decimetres for antenna offsets
  localparam int DIM_W        = 10;
  localparam int LAT_DIST_W   = 8;
  localparam int LON_DIST_W   = 10;

  // Field widths and positions inside the ME field
  localparam int SIZE_W       = 4;
  localparam int LAT_W        = 3;
  localparam int LAT_MAG_W    = 2;
  localparam int LON_W        = 5;
  localparam int SIZE_ME_MSB  = 21;
  localparam int SIZE_ME_LSB  = 24;
  localparam int LAT_DIR_ME   = 33;
  localparam int LAT_MAG_MSB  = 34;
  localparam int LAT_MAG_LSB  = 35;
  localparam int LON_ME_MSB   = 36;
  localparam int LON_ME_LSB   = 40;

  // Size category codes
  localparam int                NUM_SIZE_CODES = 15;
  localparam logic [SIZE_W-1:0] SIZE_NO_DATA   = 4'h0;
  localparam logic [SIZE_W-1:0] SIZE_OVERSIZE  = 4'hf;

  // Upper bounds per category 1..15 in half metres (index 0 unused)
  localparam logic [DIM_W-1:0] LEN_BOUND_HM [0:15] = '{
    10'h000, 10'h01e, 10'h032, 10'h032, 10'h046, 10'h046, 10'h05a, 10'h05a,
    10'h06e, 10'h06e, 10'h082, 10'h082, 10'h096, 10'h096, 10'h0aa, 10'h0aa};
  localparam logic [DIM_W-1:0] WID_BOUND_HM [0:15] = '{
    10'h000, 10'h02e, 10'h039, 10'h044, 10'h042, 10'h04c, 10'h04f, 10'h05a,
    10'h05a, 10'h068, 10'h077, 10'h086, 10'h091, 10'h0a0, 10'h0a0, 10'h0b4};

  // Offset quantisation: 2 m steps, rounded at half a step (1 m)
  localparam int OFFSET_RES_M  = 2;
  localparam int OFFSET_STEP_DM = OFFSET_RES_M * 10;
  localparam int OFFSET_HALF_DM = OFFSET_STEP_DM / 2;
  localparam int LAT_MAX_M      = 6;
  localparam int LON_MAX_M      = 60;
  localparam int LAT_MAX_STEPS  = LAT_MAX_M / OFFSET_RES_M;
  localparam int LON_MAX_STEPS  = LON_MAX_M / OFFSET_RES_M;

  // Lateral codes
  localparam logic             LAT_DIR_LEFT  = 1'b0;
  localparam logic             LAT_DIR_RIGHT = 1'b1;
  localparam logic [LAT_W-1:0] LAT_NO_DATA   = 3'h0;
  localparam logic [LAT_W-1:0] LAT_ZERO      = 3'h4;

  // Longitudinal codes
  localparam logic [LON_W-1:0] LON_NO_DATA   = 5'h00;
  localparam logic [LON_W-1:0] LON_APPLIED   = 5'h01;
  localparam logic [LON_W-1:0] LON_CODE_BIAS = 5'h01;
  localparam logic [LON_W-1:0] LON_MIN_CODE  = 5'h02;

endpackage : aoe_pkg

`default_nettype wire

// ### aoe_offset_quant.sv
`default_nettype none

// Rounds a distance to whole steps and saturates at a largest step count
module aoe_offset_quant #(
  parameter int DIST_W    = 8,
  parameter int OUT_W     = 2,
  parameter int STEP      = 20,
  parameter int HALF      = 10,
  parameter int MAX_STEPS = 3
) (
  input  wire logic [DIST_W-1:0] dist_i,
  output logic      [OUT_W-1:0]  steps_o,
  output logic                   sat_o
);

  logic [DIST_W:0] sum;
  logic [DIST_W:0] quot;

  // Adding half a step before the divide gives nearest-step rounding
  always_comb begin
    sum     = {1'b0, dist_i} + (DIST_W+1)'(HALF);
    quot    = sum / (DIST_W+1)'(STEP);
    sat_o   = quot > (DIST_W+1)'(MAX_STEPS);
    steps_o = sat_o ? OUT_W'(MAX_STEPS) : quot[OUT_W-1:0];
  end

endmodule // aoe_offset_quant

`default_nettype wire

// ### aoe_src_model.sv
`default_nettype none
// Avionics data source: holds every field until the next update
module aoe_src_model (
  output logic       dim_valid_o,
  output logic [9:0] length_o,
  output logic [9:0] width_o,
  output logic       lat_valid_o,
  output logic       lat_right_o,
  output logic [7:0] lat_dist_o,
  output logic       lon_valid_o,
  output logic       lon_applied_o,
  output logic [9:0] lon_dist_o
);
  // Invalid dimensions and distances carry inverted junk, so a stale value never passes for data
  task automatic put(input logic dv, input logic [9:0] l, w, input logic lv, r, input logic [7:0] d,
                     input logic nv, a, input logic [9:0] n);
    dim_valid_o = dv;
    length_o = dv ? l : ~l;
    width_o = dv ? w : ~w;
    lat_valid_o = lv;
    lat_right_o = r;
    lat_dist_o = lv ? d : ~d;
    lon_valid_o = nv;
    lon_applied_o = a;
    lon_dist_o = nv ? n : ~n;
  endtask
endmodule // aoe_src_model
`default_nettype wire

// ### aoe_size_offset_enc_checker.sv
`default_nettype none
// Every output is judged on the edge after the inputs that caused it
module aoe_size_offset_enc_checker (
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic       dim_valid_i,
  input wire logic [9:0] length_hm_i,
  input wire logic [9:0] width_hm_i,
  input wire logic       lat_valid_i,
  input wire logic       lat_right_i,
  input wire logic [7:0] lat_dist_dm_i,
  input wire logic       lon_valid_i,
  input wire logic       lon_applied_i,
  input wire logic [9:0] lon_dist_dm_i,
  input wire logic [3:0] size_code_o,
  input wire logic [2:0] lat_code_o,
  input wire logic [4:0] lon_code_o,
  input wire logic       size_over_o,
  input wire logic       lat_sat_o,
  input wire logic       lon_sat_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // At least 1 m off axis rounds to a nonzero step
  sequence s_lat_off; lat_valid_i && lat_dist_dm_i >= 8'h0a; endsequence
  property p_size_over; dim_valid_i && (length_hm_i > 10'h0aa || width_hm_i > 10'h0b4)
    |=> size_over_o && size_code_o == 4'hf; endproperty
  a_size_over: assert property (p_size_over) else $error("oversize not coded 15");
  property p_size_none; !dim_valid_i |=> size_code_o == 4'h0 && !size_over_o; endproperty
  a_size_none: assert property (p_size_none) else $error("size no-data wrong");
  property p_lat_none; !lat_valid_i |=> lat_code_o == 3'h0; endproperty
  a_lat_none: assert property (p_lat_none) else $error("lateral no-data wrong");
  property p_lat_dir; s_lat_off |=> lat_code_o[2] == $past(lat_right_i) && lat_code_o[1:0] != 2'h0; endproperty
  a_lat_dir: assert property (p_lat_dir) else $error("lateral direction wrong");
  property p_lat_sat; lat_valid_i && lat_dist_dm_i >= 8'h46 |=> lat_sat_o && lat_code_o[1:0] == 2'h3; endproperty
  a_lat_sat: assert property (p_lat_sat) else $error("lateral not clamped");
  property p_lon_app; lon_valid_i && lon_applied_i |=> lon_code_o == 5'h01 && !lon_sat_o; endproperty
  a_lon_app: assert property (p_lon_app) else $error("applied code wrong");
  property p_lon_sat; lon_valid_i && !lon_applied_i && lon_dist_dm_i >= 10'h262
    |=> lon_sat_o && lon_code_o == 5'h1f; endproperty
  a_lon_sat: assert property (p_lon_sat) else $error("longitudinal not clamped");
  property p_lon_none; !lon_valid_i |=> lon_code_o == 5'h00; endproperty
  a_lon_none: assert property (p_lon_none) else $error("longitudinal no-data wrong");
endmodule // aoe_size_offset_enc_checker
bind aoe_size_offset_enc aoe_size_offset_enc_checker aoe_size_offset_enc_checker_inst (.*);
`default_nettype wire

// ### tb_aoe_size_offset_enc.sv
`default_nettype none
// Source updates on falling edges; the registered answer is read one cycle later
module tb_aoe_size_offset_enc;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       dim_valid_i, lat_valid_i, lat_right_i, lon_valid_i, lon_applied_i, size_over_o, lat_sat_o, lon_sat_o;
  logic [9:0] length_hm_i, width_hm_i, lon_dist_dm_i;
  logic [7:0] lat_dist_dm_i;
  logic [3:0] size_code_o;
  logic [2:0] lat_code_o;
  logic [4:0] lon_code_o;
  int         num_errors = 0;
  int         checks_done = 0;
  always #50 clock_i = ~clock_i;
  aoe_src_model aoe_src_model_inst (.dim_valid_o(dim_valid_i), .length_o(length_hm_i), .width_o(width_hm_i),
    .lat_valid_o(lat_valid_i), .lat_right_o(lat_right_i), .lat_dist_o(lat_dist_dm_i), .lon_valid_o(lon_valid_i),
    .lon_applied_o(lon_applied_i), .lon_dist_o(lon_dist_dm_i));
  aoe_size_offset_enc aoe_size_offset_enc_inst (.*);
  // Flag and code are compared together, flag on top
  task automatic check(input string n, input logic [5:0] e, g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic step(input logic dv, input logic [9:0] l, w, input logic lv, r, input logic [7:0] d,
                      input logic nv, a, input logic [9:0] n);
    @(negedge clock_i);
    aoe_src_model_inst.put(dv, l, w, lv, r, d, nv, a, n);
    @(negedge clock_i);
  endtask
  task automatic t_size(input logic v, input logic [9:0] l, w, input logic [3:0] e, input logic o);
    step(v, l, w, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 10'h000);
    check("size", {1'b0, o, e}, {1'b0, size_over_o, size_code_o});
  endtask
  task automatic t_lat(input logic v, r, input logic [7:0] d, input logic [2:0] e, input logic s);
    step(1'b0, 10'h000, 10'h000, v, r, d, 1'b0, 1'b0, 10'h000);
    check("lat", {2'h0, s, e}, {2'h0, lat_sat_o, lat_code_o});
  endtask
  task automatic t_lon(input logic v, a, input logic [9:0] n, input logic [4:0] e, input logic s);
    step(1'b0, 10'h000, 10'h000, 1'b0, 1'b0, 8'h00, v, a, n);
    check("lon", {s, e}, {lon_sat_o, lon_code_o});
  endtask
  // Mid-run reset clears at once; the first edge after release brings the data back
  task automatic run_reset;
    t_size(1'b1, 10'h030, 10'h064, 4'h9, 1'b0);
    rst_n_i = 1'b0;
    #10;
    check("rst", 6'h00, {1'b0, size_over_o, size_code_o});
    @(negedge clock_i);
    rst_n_i = 1'b1;
    @(negedge clock_i);
    check("rel", 6'h09, {1'b0, size_over_o, size_code_o});
  endtask
  initial begin
    aoe_src_model_inst.put(1'b0, 10'h000, 10'h000, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 10'h000);
    repeat (3) @(negedge clock_i);
    check("rst", 6'h00, {1'b0, size_over_o, size_code_o});
    check("rst_lat", 6'h00, {2'h0, lat_sat_o, lat_code_o});
    check("rst_lon", 6'h00, {lon_sat_o, lon_code_o});
    rst_n_i = 1'b1;
    t_size(1'b1, 10'h01e, 10'h02e, 4'h1, 1'b0);
    t_size(1'b1, 10'h01f, 10'h02e, 4'h2, 1'b0);
    t_size(1'b1, 10'h046, 10'h043, 4'h5, 1'b0);
    t_size(1'b1, 10'h0aa, 10'h0a0, 4'he, 1'b0);
    t_size(1'b1, 10'h0aa, 10'h0b4, 4'hf, 1'b0);
    t_size(1'b1, 10'h0ab, 10'h000, 4'hf, 1'b1);
    t_size(1'b1, 10'h000, 10'h0b5, 4'hf, 1'b1);
    t_size(1'b0, 10'h030, 10'h064, 4'h0, 1'b0);
    t_lat(1'b1, 1'b1, 8'h23, 3'h6, 1'b0);
    t_lat(1'b1, 1'b0, 8'h09, 3'h4, 1'b0);
    t_lat(1'b1, 1'b0, 8'h0a, 3'h1, 1'b0);
    t_lat(1'b1, 1'b1, 8'h1d, 3'h5, 1'b0);
    t_lat(1'b1, 1'b0, 8'h45, 3'h3, 1'b0);
    t_lat(1'b1, 1'b1, 8'h46, 3'h7, 1'b1);
    t_lat(1'b0, 1'b1, 8'h23, 3'h0, 1'b0);
    t_lat(1'b1, 1'b1, 8'h00, 3'h4, 1'b0);
    t_lon(1'b1, 1'b0, 10'h028, 5'h03, 1'b0);
    t_lon(1'b1, 1'b1, 10'h1f4, 5'h01, 1'b0);
    t_lon(1'b1, 1'b0, 10'h01d, 5'h02, 1'b0);
    t_lon(1'b1, 1'b0, 10'h01e, 5'h03, 1'b0);
    t_lon(1'b1, 1'b0, 10'h261, 5'h1f, 1'b0);
    t_lon(1'b1, 1'b0, 10'h262, 5'h1f, 1'b1);
    t_lon(1'b0, 1'b1, 10'h028, 5'h00, 1'b0);
    t_lon(1'b1, 1'b0, 10'h009, 5'h02, 1'b0);
    run_reset();
    print_verdict();
  end
  // About 60 cycles of tests; a generous margin cuts a hang short
  initial begin
    #40000;
    num_errors++;
    print_verdict();
  end
endmodule // tb_aoe_size_offset_enc
`default_nettype wire
